/* hdl/cidfs_device.sv */
// Decodes the select lines and drives the shared ready or steering output.
// Assumes the selects, word-end and tone-qualified inputs are synchronous.

// Holds one decoded enable level in a flop with a chosen value after reset.
module cidfs_level_flop #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_d,
    output logic      o_q
);
    import cidfs_pkg::*;

    logic level_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            level_q <= RESET_VALUE;
        end else begin
            level_q <= i_d;
        end
    end

    assign o_q = level_q;
endmodule

module cidfs_device
    import cidfs_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,
    cidfs_sel_if.device            sel,
    input  wire logic              i_word_end,
    input  wire logic              i_tone_qualified,
    output cidfs_pkg::cidfs_func_t o_function,
    output logic                   o_if_mode,
    output logic                   o_line_amp_sel,
    output logic                   o_handset_amp_sel,
    output logic                   o_demod_en,
    output logic                   o_tone_en,
    output logic                   o_power_down,
    output logic                   o_ready_or_steer_out_n
);
    import cidfs_pkg::*;

    cidfs_func_t func_d;
    cidfs_func_t func_q;
    logic        if_mode_q;
    logic        demod_en_d;
    logic        tone_en_d;
    logic        line_amp_sel_d;
    logic        handset_amp_sel_d;
    logic        power_down_d;
    logic        word_ready_strobe_n_q;
    logic [14:0] half_cnt_q;
    logic        half_bit_done;
    logic        qualified_tone_strobe_n_q;

    // Decodes the two function selects; both low also needs the interface select.
    always_comb begin
        unique case ({sel.high_function_select, sel.low_function_select})
            2'b11: func_d = CIDFS_FN_DEMOD;     // [R1]
            2'b10: func_d = CIDFS_FN_HYB_TONE;  // [R2]
            2'b01: func_d = CIDFS_FN_LINE_TONE; // [R3]
            2'b00: func_d = sel.interface_select ? CIDFS_FN_PWRDN : CIDFS_FN_TEST; // [R4]
        endcase
    end

    // Decodes the enables from the next function so they switch together with it.
    always_comb begin
        demod_en_d        = 1'b0;
        tone_en_d         = 1'b0;
        line_amp_sel_d    = 1'b0;
        handset_amp_sel_d = 1'b0;
        power_down_d      = 1'b0;
        unique case (func_d)
            CIDFS_FN_DEMOD: begin
                demod_en_d     = 1'b1; // [R1]
                line_amp_sel_d = 1'b1; // [R1]
            end
            CIDFS_FN_HYB_TONE: begin
                tone_en_d         = 1'b1; // [R2]
                handset_amp_sel_d = 1'b1; // [R2]
            end
            CIDFS_FN_LINE_TONE: begin
                tone_en_d      = 1'b1; // [R3]
                line_amp_sel_d = 1'b1; // [R3]
            end
            CIDFS_FN_PWRDN: begin
                power_down_d = 1'b1; // [R4]
            end
            CIDFS_FN_TEST: begin
                power_down_d = 1'b0;
            end
        endcase
    end

    // Holds the decoded function.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            func_q <= FUNC_RESET;
        end else begin
            func_q <= func_d;
        end
    end

    // Holds the data interface mode.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            if_mode_q <= IF_MODE_RESET;
        end else begin
            if_mode_q <= sel.interface_select; // [R5]
        end
    end

    // Registers each enable level.
    cidfs_level_flop #(
        .RESET_VALUE(DEMOD_RESET)
    ) demod_flop_inst (
        .i_clk_sys(i_clk_sys),
        .i_rst_n  (i_rst_n),
        .i_d      (demod_en_d),
        .o_q      (o_demod_en)
    );

    cidfs_level_flop #(
        .RESET_VALUE(TONE_RESET)
    ) tone_flop_inst (
        .i_clk_sys(i_clk_sys),
        .i_rst_n  (i_rst_n),
        .i_d      (tone_en_d),
        .o_q      (o_tone_en)
    );

    cidfs_level_flop #(
        .RESET_VALUE(LINE_AMP_RESET)
    ) line_amp_flop_inst (
        .i_clk_sys(i_clk_sys),
        .i_rst_n  (i_rst_n),
        .i_d      (line_amp_sel_d),
        .o_q      (o_line_amp_sel)
    );

    cidfs_level_flop #(
        .RESET_VALUE(HYB_AMP_RESET)
    ) handset_amp_flop_inst (
        .i_clk_sys(i_clk_sys),
        .i_rst_n  (i_rst_n),
        .i_d      (handset_amp_sel_d),
        .o_q      (o_handset_amp_sel)
    );

    cidfs_level_flop #(
        .RESET_VALUE(PWRDN_RESET)
    ) power_down_flop_inst (
        .i_clk_sys(i_clk_sys),
        .i_rst_n  (i_rst_n),
        .i_d      (power_down_d),
        .o_q      (o_power_down)
    );

    assign half_bit_done = (half_cnt_q == HALF_BIT_LAST);

    // Counts the half bit while the ready strobe is low; each word end restarts it.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            half_cnt_q <= HALF_CNT_RESET;
        end else if (!o_demod_en || i_word_end || word_ready_strobe_n_q) begin
            half_cnt_q <= HALF_CNT_RESET;
        end else if (!half_bit_done) begin
            half_cnt_q <= half_cnt_q + 15'h0001; // [R10]
        end
    end

    // Ready strobe idles high and is held low for half a bit after each word end.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word_ready_strobe_n_q <= STROBE_IDLE;
        end else if (!o_demod_en) begin
            word_ready_strobe_n_q <= STROBE_IDLE;
        end else if (i_word_end) begin
            word_ready_strobe_n_q <= 1'b0; // [R10]
        end else if (!word_ready_strobe_n_q && half_bit_done) begin
            word_ready_strobe_n_q <= STROBE_IDLE; // [R10]
        end
    end

    // Steering strobe follows the qualified tone in either tone mode.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            qualified_tone_strobe_n_q <= STROBE_IDLE;
        end else begin
            qualified_tone_strobe_n_q <= !(o_tone_en && i_tone_qualified); // [R11]
        end
    end

    assign o_function = func_q;
    assign o_if_mode  = if_mode_q;

    // Routes the strobe that belongs to the current function onto the shared pin.
    always_comb begin
        if (o_demod_en) begin
            o_ready_or_steer_out_n = word_ready_strobe_n_q; // [R1]
        end else if (o_tone_en) begin
            o_ready_or_steer_out_n = qualified_tone_strobe_n_q; // [R2] [R3]
        end else begin
            o_ready_or_steer_out_n = STROBE_IDLE; // [R4]
        end
    end
endmodule

/* hdl/cidfs_host.sv */
// Drives the three select lines from a requested function and mode.
// Assumes requests are synchronous; an illegal request keeps the last selection.
module cidfs_host
    import cidfs_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,
    cidfs_sel_if.host              sel,
    input  wire logic              i_req,
    input  cidfs_pkg::cidfs_func_t i_func,
    input  wire logic              i_if_mode,
    output logic                   o_refused
);
    import cidfs_pkg::*;

    logic if_q;
    logic high_q;
    logic low_q;
    logic refused_q;
    logic legal;

    // Power down forces interface select high; test state is never driven.
    assign legal = (i_func != CIDFS_FN_TEST); // [R9]

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            if_q      <= SEL_RESET_IF;
            high_q    <= SEL_RESET_HIGH;
            low_q     <= SEL_RESET_LOW;
            refused_q <= 1'b0;
        end else begin
            refused_q <= i_req && !legal;
            if (i_req && legal) begin
                unique case (i_func)
                    CIDFS_FN_DEMOD: begin
                        high_q <= 1'b1;
                        low_q  <= 1'b1;
                        if_q   <= i_if_mode; // [R5]
                    end
                    CIDFS_FN_HYB_TONE: begin
                        high_q <= 1'b1; // [R6]
                        low_q  <= 1'b0;
                        if_q   <= i_if_mode;
                    end
                    CIDFS_FN_LINE_TONE: begin
                        high_q <= 1'b0;
                        low_q  <= 1'b1;
                        if_q   <= i_if_mode;
                    end
                    default: begin
                        high_q <= 1'b0;
                        low_q  <= 1'b0;
                        if_q   <= 1'b1; // [R7] [R8]
                    end
                endcase
            end
        end
    end

    assign sel.interface_select     = if_q;
    assign sel.high_function_select = high_q;
    assign sel.low_function_select  = low_q;
    assign o_refused                = refused_q;
endmodule

/* hdl/cidfs_pkg.sv */
// Holds the shared constants and types of the caller-ID function selector.
// Assumes both ends run on one 25 MHz clock with an active-low async reset.
// What this block does
// [R1] Select 11: demodulate line input, word-ready strobe.
// [R2] Select 10: hybrid tone detect, steering strobe.
// [R3] Select 01: line tone detect, steering strobe.
// [R4] Interface 1, selects 00: full power down.
// [R5] Interface select picks data interface mode.
// [R6] Host may tie high select, toggle low.
// [R7] Tied interface select high for power down.
// [R8] Mode 0 with power down: drive all three.
// [R9] Host never drives all three selects low.
// [R10] Ready strobe idles high, low half bit.
// [R11] Steering strobe low on qualified tone.
package cidfs_pkg;
    typedef enum logic [2:0] {
        CIDFS_FN_DEMOD,
        CIDFS_FN_HYB_TONE,
        CIDFS_FN_LINE_TONE,
        CIDFS_FN_PWRDN,
        CIDFS_FN_TEST
    } cidfs_func_t;

    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned BAUD           = 1200;
    localparam int unsigned HALF_BIT_CYC   = CLK_HZ / (2 * BAUD);
    localparam logic [14:0] HALF_BIT_LAST  = 15'(HALF_BIT_CYC - 1);
    localparam logic        SEL_RESET_HIGH = 1'b1;
    localparam logic        SEL_RESET_LOW  = 1'b0;
    localparam logic        SEL_RESET_IF   = 1'b1;
    localparam cidfs_func_t FUNC_RESET     = CIDFS_FN_PWRDN;
    localparam logic        IF_MODE_RESET  = 1'b1;
    localparam logic        STROBE_IDLE    = 1'b1;
    localparam logic [14:0] HALF_CNT_RESET = 15'h0000;
    localparam logic        DEMOD_RESET    = 1'b0;
    localparam logic        TONE_RESET     = 1'b0;
    localparam logic        LINE_AMP_RESET = 1'b0;
    localparam logic        HYB_AMP_RESET  = 1'b0;
    localparam logic        PWRDN_RESET    = 1'b1;
endpackage

/* hdl/cidfs_sel_if.sv */
// Carries the three select lines from the host to the receiver.
// Assumes both ends share the system clock.
interface cidfs_sel_if;
    logic interface_select;
    logic high_function_select;
    logic low_function_select;

    modport device (input interface_select, high_function_select, low_function_select);
    modport host   (output interface_select, high_function_select, low_function_select);
endinterface

/* test/cidfs_bench.sv */
// Joins host and device through the select interface and checks both.
// Assumes the clock at 40 ns and reset held for six cycles.
module cidfs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import cidfs_pkg::*;
    logic i_clk_sys = 0, i_rst_n = 0, i_req = 0, i_if_mode = 0;
    logic i_word_end = 0, i_tone_qualified = 0, r;
    logic o_if_mode, o_refused, o_ready_or_steer_out_n;
    logic o_line_amp_sel, o_handset_amp_sel, o_demod_en, o_tone_en, o_power_down;
    cidfs_func_t i_func = CIDFS_FN_DEMOD, o_function;
    int fail_count = 0, comparisons = 0, n;
    cidfs_sel_if sel();
    cidfs_device cidfs_device_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .sel(sel),
        .i_word_end(i_word_end), .i_tone_qualified(i_tone_qualified),
        .o_function(o_function), .o_if_mode(o_if_mode), .o_line_amp_sel(o_line_amp_sel),
        .o_handset_amp_sel(o_handset_amp_sel), .o_demod_en(o_demod_en),
        .o_tone_en(o_tone_en), .o_power_down(o_power_down),
        .o_ready_or_steer_out_n(o_ready_or_steer_out_n));
    cidfs_host cidfs_host_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .sel(sel),
        .i_req(i_req), .i_func(i_func), .i_if_mode(i_if_mode), .o_refused(o_refused));
    cidfs_sel_asserts cidfs_sel_asserts_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .interface_select(sel.interface_select), .high_function_select(sel.high_function_select),
        .low_function_select(sel.low_function_select), .i_word_end(i_word_end),
        .i_tone_qualified(i_tone_qualified), .o_function(o_function), .o_if_mode(o_if_mode),
        .o_ready_or_steer_out_n(o_ready_or_steer_out_n));
    initial forever #20 i_clk_sys = ~i_clk_sys;
    task automatic chk_b(input string s, input logic e, input logic v);
        comparisons++;
        if (v !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", s, e, v);
        end
    endtask
    task automatic chk_f(input cidfs_func_t e);
        comparisons++;
        if (o_function !== e) begin
            fail_count++;
            $display("[FAIL] o_function expected %0d seen %0d", e, o_function);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic req(input cidfs_func_t f, input logic m);
        @(negedge i_clk_sys);
        i_req = 1;
        i_func = f;
        i_if_mode = m;
        @(negedge i_clk_sys);
        i_req = 0;
        r = o_refused;
        repeat (2) @(negedge i_clk_sys);
    endtask
    task automatic sels(input logic a, input logic b, input logic c);
        chk_b("interface_select", a, sel.interface_select);
        chk_b("high_function_select", b, sel.high_function_select);
        chk_b("low_function_select", c, sel.low_function_select);
    endtask
    initial begin
        repeat (6) @(negedge i_clk_sys);
        chk_f(CIDFS_FN_PWRDN);
        chk_b("o_power_down", 1'b1, o_power_down);
        chk_b("strobe", 1'b1, o_ready_or_steer_out_n);
        i_rst_n = 1;
        repeat (2) @(negedge i_clk_sys);
        sels(1'b1, 1'b1, 1'b0);
        chk_f(CIDFS_FN_HYB_TONE);
        i_tone_qualified = 1;
        @(negedge i_clk_sys);
        chk_b("strobe", 1'b0, o_ready_or_steer_out_n);
        i_tone_qualified = 0;
        for (int m = 0; m < 2; m++) begin
            for (int f = 0; f < 3; f++) begin
                req(cidfs_func_t'(f), 1'(m));
                sels(1'(m), 1'(f != 2), 1'(f != 1));
                chk_f(cidfs_func_t'(f));
                chk_b("o_if_mode", 1'(m), o_if_mode);
                chk_b("o_line_amp_sel", 1'(f != 1), o_line_amp_sel);
                chk_b("o_handset_amp_sel", 1'(f == 1), o_handset_amp_sel);
                chk_b("o_demod_en", 1'(f == 0), o_demod_en);
                chk_b("o_tone_en", 1'(f != 0), o_tone_en);
                chk_b("o_power_down", 1'b0, o_power_down);
            end
        end
        req(CIDFS_FN_PWRDN, 1'b0);
        chk_b("o_refused", 1'b0, r);
        sels(1'b1, 1'b0, 1'b0);
        chk_f(CIDFS_FN_PWRDN);
        chk_b("o_power_down", 1'b1, o_power_down);
        req(CIDFS_FN_TEST, 1'b0);
        chk_b("o_refused", 1'b1, r);
        sels(1'b1, 1'b0, 1'b0);
        req(CIDFS_FN_DEMOD, 1'b1);
        i_word_end = 1;
        @(negedge i_clk_sys);
        i_word_end = 0;
        @(negedge i_clk_sys);
        chk_b("strobe", 1'b0, o_ready_or_steer_out_n);
        n = 0;
        while (o_ready_or_steer_out_n !== 1'b1 && n < 11000) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n >= 11000) begin
            fail_count++;
        end else begin
            // The first low cycle passed before the count began.
            chk_b("low_cycles", 1'b1, n == HALF_BIT_CYC - 1);
            req(CIDFS_FN_LINE_TONE, 1'b1);
            i_tone_qualified = 1;
            @(negedge i_clk_sys);
            chk_b("strobe", 1'b0, o_ready_or_steer_out_n);
            i_tone_qualified = 0;
            @(negedge i_clk_sys);
            chk_b("strobe", 1'b1, o_ready_or_steer_out_n);
        end
        print_verdict();
    end
endmodule

/* test/cidfs_sel_asserts.sv */
// Checks the select decode and the shared strobe.
// Assumes one clock, async active-low reset.
module cidfs_sel_asserts
    import cidfs_pkg::*;
(
    input wire logic              i_clk_sys,
    input wire logic              i_rst_n,
    input wire logic              interface_select,
    input wire logic              high_function_select,
    input wire logic              low_function_select,
    input wire logic              i_word_end,
    input wire logic              i_tone_qualified,
    input cidfs_pkg::cidfs_func_t o_function,
    input wire logic              o_if_mode,
    input wire logic              o_ready_or_steer_out_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    wire logic h = high_function_select;
    wire logic l = low_function_select;
    wire logic tn = o_function inside {CIDFS_FN_HYB_TONE, CIDFS_FN_LINE_TONE};
    property p_demod; h && l |=> o_function == CIDFS_FN_DEMOD; endproperty
    a_demod: assert property (p_demod) else $error("demod decode");
    property p_hyb; h && !l |=> o_function == CIDFS_FN_HYB_TONE; endproperty
    a_hyb: assert property (p_hyb) else $error("hybrid decode");
    property p_line; !h && l |=> o_function == CIDFS_FN_LINE_TONE; endproperty
    a_line: assert property (p_line) else $error("line decode");
    property p_pdn; interface_select && !h && !l |=> o_function == CIDFS_FN_PWRDN; endproperty
    a_pdn: assert property (p_pdn) else $error("power down decode");
    property p_mode; 1 |=> o_if_mode == $past(interface_select); endproperty
    a_mode: assert property (p_mode) else $error("interface mode");
    property p_nozero; interface_select || h || l; endproperty
    a_nozero: assert property (p_nozero) else $error("test state driven");
    property p_rdy; o_function == CIDFS_FN_DEMOD && i_word_end ##1
        o_function == CIDFS_FN_DEMOD |-> !o_ready_or_steer_out_n; endproperty
    a_rdy: assert property (p_rdy) else $error("ready strobe");
    property p_steer; tn && i_tone_qualified ##1 tn |-> !o_ready_or_steer_out_n; endproperty
    a_steer: assert property (p_steer) else $error("steering strobe");
    property p_idle; o_function == CIDFS_FN_PWRDN [*2] |-> o_ready_or_steer_out_n; endproperty
    a_idle: assert property (p_idle) else $error("strobe in power down");
    c_demod: cover property (h && l && i_word_end);
    c_tone: cover property (tn && i_tone_qualified);
    c_pdn: cover property (o_function == CIDFS_FN_PWRDN);
endmodule
